// >>> fsw_pkg.sv
// Constants for the fail-safe I/O image and watchdog block
`default_nettype none

package fsw_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam int TEST_NS = 2000;
	localparam int TEST_CYC = (TEST_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------------------------------
	// Image sizes in bytes and channel counts
	// ----------------------------------------------------------------
	localparam int DI_IN_BYTES = 9;
	localparam int DI_OUT_BYTES = 5;
	localparam int DQ_IN_BYTES = 6;
	localparam int DQ_OUT_BYTES = 6;
	localparam int DI_CH = 16;
	localparam int DQ_CH = 4;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DI_ACT = 8'h04;
	localparam logic [7:0] OFS_DI_PASS = 8'h08;
	localparam logic [7:0] OFS_DQ_CFG = 8'h0C;
	localparam logic [7:0] OFS_MON_OWN = 8'h10;
	localparam logic [7:0] OFS_MON_DEF = 8'h14;
	localparam logic [7:0] OFS_FRAME = 8'h18;
	localparam logic [7:0] OFS_DI_IMG0 = 8'h1C;
	localparam logic [7:0] OFS_DI_IMG1 = 8'h20;
	localparam logic [7:0] OFS_DI_IMG2 = 8'h24;
	localparam logic [7:0] OFS_DQ_IMG0 = 8'h28;
	localparam logic [7:0] OFS_DQ_IMG1 = 8'h2C;
	localparam logic [7:0] OFS_DQ_OIMG0 = 8'h30;
	localparam logic [7:0] OFS_DQ_OIMG1 = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	localparam logic [7:0] OFS_DEST = 8'h3C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_PAIR = 0;
	localparam int CTRL_SCT = 1;
	localparam int CTRL_OWN_MON = 2;
	localparam int CTRL_REINT = 3;
	localparam int DQ_PASS_LSB = 4;
	localparam int FRM_OK = 4;
	localparam int FRM_DEST_LSB = 8;
	localparam int FRM_SEQ_LSB = 16;
	localparam int STAT_SC_LSB = 16;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_RST = 4'h2;
	localparam logic [15:0] DI_ACT_RST = 16'hFFFF;
	localparam logic [7:0] DQ_CFG_RST = 8'h0F;
	localparam logic [15:0] MON_DEF_RST = 16'h0096;
	localparam logic [7:0] DEST_RST = 8'h01;

	// Watchdog states, Gray along safe -> arm -> run
	typedef enum logic [1:0] {
		ST_SAFE = 2'b00,
		ST_ARM = 2'b01,
		ST_RUN = 2'b11
	} fsw_state_t;

endpackage

`default_nettype wire

// >>> fsw_top.sv
// Fail-safe I/O image mapping, validity bits and frame watchdog
//
// Contract
// - Single mode: values bytes 0-1, validity bytes 2-3
// - Paired mode: validity only in byte 2
// - Paired channels report through lower channel bit
// - Validity bit high for good, low bad
// - Passivated channel or module clears validity
// - Watchdog enters safe state without fresh frame
// - Output values low nibble, validity returned likewise
// - Output module uses six in, six out bytes
// - Monitoring time defaults to controller-wide value
// - Cleared activation marks output channel unused
// - Input short-circuit test can be disabled
// - Input module uses nine in, five out bytes
`timescale 1ns/1ps
`default_nettype none

module fsw_top import fsw_pkg::*; #(
	parameter int MS_CYCLES = MS_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [7:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [15:0] DI_PIN,
	output logic [3:0] DQ_PIN,
	output logic SENSOR_SUPPLY,
	output logic SAFE_STATE
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Word w of a packed byte image, bytes beyond the image read zero
	function automatic logic [31:0] img_word(input logic [95:0] v,
			input int w);
		img_word = v[32 * w +: 32];
	endfunction

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	logic [15:0] s1_r, s2_r, s3_r, di_f_r, di_f_nxt;

	// Accept a change once second and third stage agree
	always_comb begin
		di_f_nxt = di_f_r;
		for (int i = 0; i < DI_CH; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				di_f_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s1_r <= 16'h0000;
			s2_r <= 16'h0000;
			s3_r <= 16'h0000;
			di_f_r <= 16'h0000;
		end else begin
			s1_r <= DI_PIN;
			s2_r <= s1_r;
			s3_r <= s2_r;
			di_f_r <= di_f_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Millisecond tick and short-circuit test pulse
	// ----------------------------------------------------------------
	logic [31:0] ms_cnt_r, ms_cnt_nxt;
	logic [15:0] tst_cnt_r, tst_cnt_nxt;
	logic ms_tick;
	logic tst_on;
	logic tst_end;
	logic [3:0] ctrl_r, ctrl_nxt;

	assign ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
	assign tst_on = (tst_cnt_r != 16'h0000);
	assign tst_end = (tst_cnt_r == 16'h0001);

	// Divider, and a test pulse started on a tick when enabled and no pulse is running
	always_comb begin
		ms_cnt_nxt = ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
		tst_cnt_nxt = tst_cnt_r;
		if (tst_on) begin
			tst_cnt_nxt = tst_cnt_r - 16'h0001;
		end else if (ms_tick && ctrl_r[CTRL_SCT]) begin
			tst_cnt_nxt = 16'(TEST_CYC);
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ms_cnt_r <= 32'h0000_0000;
			tst_cnt_r <= 16'h0000;
		end else begin
			ms_cnt_r <= ms_cnt_nxt;
			tst_cnt_r <= tst_cnt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [15:0] di_act_r, di_act_nxt;
	logic [15:0] di_pass_r, di_pass_nxt;
	logic [7:0] dq_cfg_r, dq_cfg_nxt;
	logic [15:0] mon_own_r, mon_own_nxt;
	logic [15:0] mon_def_r, mon_def_nxt;
	logic [7:0] dest_r, dest_nxt;
	logic wr_acc;
	logic rd_setup;
	logic reint_req;
	logic frame_wr;

	assign wr_acc = PSEL && PENABLE && PWRITE;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign reint_req = wr_acc && (PADDR == OFS_CTRL) && PWDATA[CTRL_REINT];
	assign frame_wr = wr_acc && (PADDR == OFS_FRAME);

	// Writes take effect in the access phase
	always_comb begin
		ctrl_nxt = ctrl_r;
		di_act_nxt = di_act_r;
		di_pass_nxt = di_pass_r;
		dq_cfg_nxt = dq_cfg_r;
		mon_own_nxt = mon_own_r;
		mon_def_nxt = mon_def_r;
		dest_nxt = dest_r;
		ctrl_nxt[CTRL_REINT] = 1'b0;
		if (wr_acc) begin
			if (PADDR == OFS_CTRL) begin
				ctrl_nxt = {1'b0, PWDATA[2:0]};
			end else if (PADDR == OFS_DI_ACT) begin
				di_act_nxt = PWDATA[15:0];
			end else if (PADDR == OFS_DI_PASS) begin
				di_pass_nxt = PWDATA[15:0];
			end else if (PADDR == OFS_DQ_CFG) begin
				dq_cfg_nxt = PWDATA[7:0];
			end else if (PADDR == OFS_MON_OWN) begin
				mon_own_nxt = PWDATA[15:0];
			end else if (PADDR == OFS_MON_DEF) begin
				mon_def_nxt = PWDATA[15:0];
			end else if (PADDR == OFS_DEST) begin
				dest_nxt = PWDATA[7:0];
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_r <= CTRL_RST;
			di_act_r <= DI_ACT_RST;
			di_pass_r <= 16'h0000;
			dq_cfg_r <= DQ_CFG_RST;
			mon_own_r <= 16'h0000;
			mon_def_r <= MON_DEF_RST;
			dest_r <= DEST_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			di_act_r <= di_act_nxt;
			di_pass_r <= di_pass_nxt;
			dq_cfg_r <= dq_cfg_nxt;
			mon_own_r <= mon_own_nxt;
			mon_def_r <= mon_def_nxt;
			dest_r <= dest_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Frame check and watchdog
	// ----------------------------------------------------------------
	fsw_state_t st_r, st_nxt;
	logic [15:0] seq_r, seq_nxt;
	logic [15:0] age_r, age_nxt;
	logic [3:0] dq_val_r, dq_val_nxt;
	logic [15:0] mon_time;
	logic frame_good;
	logic expired;

	// Own time only when selected and non-zero
	assign mon_time = (ctrl_r[CTRL_OWN_MON] && mon_own_r != 16'h0000) ?
		mon_own_r : mon_def_r;
	// Valid, addressed to us, and exactly one past the last sequence number
	assign frame_good = frame_wr && PWDATA[FRM_OK] &&
		(PWDATA[FRM_DEST_LSB +: 8] == dest_r) &&
		(PWDATA[FRM_SEQ_LSB +: 16] == seq_r + 16'h0001);
	assign expired = (age_r >= mon_time);

	// Safe -> arm on reintegration, arm -> run on a good frame
	always_comb begin
		st_nxt = st_r;
		seq_nxt = seq_r;
		age_nxt = age_r;
		dq_val_nxt = dq_val_r;
		if (ms_tick && !expired) begin
			age_nxt = age_r + 16'h0001;
		end
		if (frame_good) begin
			seq_nxt = PWDATA[FRM_SEQ_LSB +: 16];
			age_nxt = 16'h0000;
			dq_val_nxt = PWDATA[3:0];
		end
		case (st_r)
			ST_SAFE: begin
				dq_val_nxt = 4'h0;
				if (reint_req) begin
					st_nxt = ST_ARM;
					age_nxt = 16'h0000;
				end
			end
			ST_ARM: begin
				if (frame_good) begin
					st_nxt = ST_RUN;
				end else if (expired) begin
					st_nxt = ST_SAFE;
				end
			end
			ST_RUN: begin
				if (expired && !frame_good) begin
					st_nxt = ST_SAFE;
				end
			end
			default: begin
				st_nxt = ST_SAFE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r <= ST_ARM;
			seq_r <= 16'h0000;
			age_r <= 16'h0000;
			dq_val_r <= 4'h0;
		end else begin
			st_r <= st_nxt;
			seq_r <= seq_nxt;
			age_r <= age_nxt;
			dq_val_r <= dq_val_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Short-circuit fault capture and input hold
	// ----------------------------------------------------------------
	logic [15:0] sc_flt_r, sc_flt_nxt;
	logic [15:0] di_use_r, di_use_nxt;

	// Input still high with supply off means a short to supply
	always_comb begin
		sc_flt_nxt = sc_flt_r;
		di_use_nxt = tst_on ? di_use_r : di_f_r;
		if (tst_end) begin
			sc_flt_nxt = sc_flt_r | (di_f_r & di_act_r);
		end else if (reint_req) begin
			sc_flt_nxt = 16'h0000;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sc_flt_r <= 16'h0000;
			di_use_r <= 16'h0000;
		end else begin
			sc_flt_r <= sc_flt_nxt;
			di_use_r <= di_use_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Process images
	// ----------------------------------------------------------------
	logic [71:0] di_img_r, di_img_nxt;
	logic [47:0] dq_img_r, dq_img_nxt;
	logic [47:0] dq_oimg_r, dq_oimg_nxt;
	logic [15:0] ch_ok;
	logic [3:0] dq_ok;
	logic [7:0] pair_ok;
	logic run;

	assign run = (st_r == ST_RUN);
	// Good channel: active, not passivated, no fault, module running
	assign ch_ok = di_act_r & ~di_pass_r & ~sc_flt_r & {16{run}};
	assign dq_ok = dq_cfg_r[3:0] & ~dq_cfg_r[DQ_PASS_LSB +: 4] &
		{4{run}};
	// Pair i with i+8, both good and in agreement
	assign pair_ok = ch_ok[7:0] & ch_ok[15:8] &
		~(di_use_r[7:0] ^ di_use_r[15:8]);

	// Assemble input and output images in byte order
	always_comb begin
		di_img_nxt = 72'h0;
		dq_img_nxt = 48'h0;
		dq_oimg_nxt = 48'h0;
		if (ctrl_r[CTRL_PAIR]) begin
			di_img_nxt[7:0] = di_use_r[7:0] & pair_ok;
			di_img_nxt[23:16] = pair_ok;
		end else begin
			di_img_nxt[15:0] = di_use_r & ch_ok;
			di_img_nxt[31:16] = ch_ok;
		end
		dq_oimg_nxt[3:0] = dq_val_r;
		dq_img_nxt[3:0] = dq_ok;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			di_img_r <= 72'h0;
			dq_img_r <= 48'h0;
			dq_oimg_r <= 48'h0;
		end else begin
			di_img_r <= di_img_nxt;
			dq_img_r <= dq_img_nxt;
			dq_oimg_r <= dq_oimg_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	logic [3:0] dq_pin_r, dq_pin_nxt;
	logic sup_r, sup_nxt;
	logic safe_r, safe_nxt;

	// Outputs de-energised unless running and channel good
	always_comb begin
		dq_pin_nxt = dq_val_r & dq_ok;
		sup_nxt = !tst_on;
		safe_nxt = (st_r == ST_SAFE);
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dq_pin_r <= 4'h0;
			sup_r <= 1'b1;
			safe_r <= 1'b0;
		end else begin
			dq_pin_r <= dq_pin_nxt;
			sup_r <= sup_nxt;
			safe_r <= safe_nxt;
		end
	end

	assign DQ_PIN = dq_pin_r;
	assign SENSOR_SUPPLY = sup_r;
	assign SAFE_STATE = safe_r;

	// ----------------------------------------------------------------
	// APB read path and response
	// ----------------------------------------------------------------
	logic [31:0] rdata_r, rdata_nxt;
	logic [95:0] di_pad;
	logic [95:0] dq_pad;
	logic [95:0] dqo_pad;
	logic mapped;

	assign di_pad = {24'h0, di_img_r};
	assign dq_pad = {48'h0, dq_img_r};
	assign dqo_pad = {48'h0, dq_oimg_r};
	assign mapped = (PADDR[1:0] == 2'b00) && (PADDR <= OFS_DEST);

	// Read data captured in the setup phase
	always_comb begin
		rdata_nxt = rdata_r;
		if (rd_setup) begin
			if (PADDR == OFS_CTRL) begin
				rdata_nxt = {29'h0, ctrl_r[2:0]};
			end else if (PADDR == OFS_DI_ACT) begin
				rdata_nxt = {16'h0, di_act_r};
			end else if (PADDR == OFS_DI_PASS) begin
				rdata_nxt = {16'h0, di_pass_r};
			end else if (PADDR == OFS_DQ_CFG) begin
				rdata_nxt = {24'h0, dq_cfg_r};
			end else if (PADDR == OFS_MON_OWN) begin
				rdata_nxt = {16'h0, mon_own_r};
			end else if (PADDR == OFS_MON_DEF) begin
				rdata_nxt = {16'h0, mon_def_r};
			end else if (PADDR == OFS_FRAME) begin
				rdata_nxt = {seq_r, 12'h0, dq_val_r};
			end else if (PADDR == OFS_DI_IMG0) begin
				rdata_nxt = img_word(di_pad, 0);
			end else if (PADDR == OFS_DI_IMG1) begin
				rdata_nxt = img_word(di_pad, 1);
			end else if (PADDR == OFS_DI_IMG2) begin
				rdata_nxt = img_word(di_pad, 2);
			end else if (PADDR == OFS_DQ_IMG0) begin
				rdata_nxt = img_word(dq_pad, 0);
			end else if (PADDR == OFS_DQ_IMG1) begin
				rdata_nxt = img_word(dq_pad, 1);
			end else if (PADDR == OFS_DQ_OIMG0) begin
				rdata_nxt = img_word(dqo_pad, 0);
			end else if (PADDR == OFS_DQ_OIMG1) begin
				rdata_nxt = img_word(dqo_pad, 1);
			end else if (PADDR == OFS_STATUS) begin
				rdata_nxt = {sc_flt_r, 14'h0, st_r};
			end else if (PADDR == OFS_DEST) begin
				rdata_nxt = {24'h0, dest_r};
			end else begin
				rdata_nxt = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Zero-wait slave; unmapped or misaligned addresses flag an error
	assign PRDATA = rdata_r;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;

endmodule // fsw_top

`default_nettype wire

// >>> fsw_top_checker.sv
// Port-level assertions for the fail-safe I/O image block
`timescale 1ns/1ps
`default_nettype none

module fsw_chk import fsw_pkg::*; #(
	parameter int MS_CYCLES = MS_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [7:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [15:0] DI_PIN,
	input wire logic [3:0] DQ_PIN,
	input wire logic SENSOR_SUPPLY,
	input wire logic SAFE_STATE
);
	logic acc;
	logic bad_addr;
	logic wr_reint;
	logic [8:0] lo_cnt_r;
	logic [8:0] lo_cnt_nxt;

	// ------------------------------------------------------------
	// Helper decode and low-pulse counter
	// ------------------------------------------------------------
	assign acc = PSEL && PENABLE;
	assign bad_addr = (PADDR[1:0] != 2'h0) || (PADDR > 8'h3C);
	assign wr_reint = acc && PWRITE && PADDR == OFS_CTRL && PWDATA[CTRL_REINT];
	always_comb begin
		lo_cnt_nxt = SENSOR_SUPPLY ? 9'h000 : lo_cnt_r + 9'h001;
	end
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			lo_cnt_r <= 9'h000;
		end else begin
			lo_cnt_r <= lo_cnt_nxt;
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	a_err_bad_addr: assert property (acc && bad_addr |-> PSLVERR)
		else $error("unmapped access without error");
	a_err_good_addr: assert property (!(acc && bad_addr) |-> !PSLVERR)
		else $error("error on mapped access or idle bus");
	a_bad_read_zero: assert property (acc && !PWRITE && bad_addr
		|-> PRDATA == 32'h0)
		else $error("unmapped read returned data");
	a_safe_outs_off: assert property (SAFE_STATE [*3] |-> DQ_PIN == 4'h0)
		else $error("outputs energised in safe state");
	a_dq_rise_run: assert property ($rose(|DQ_PIN) |-> !SAFE_STATE)
		else $error("output rose while safe");
	a_safe_exit_reint: assert property ($fell(SAFE_STATE)
		|-> $past(wr_reint) || $past(wr_reint, 2))
		else $error("safe state left without reintegration");
	a_pulse_min_len: assert property ($fell(SENSOR_SUPPLY) |-> !SENSOR_SUPPLY [*8])
		else $error("test pulse too short");
	a_pulse_max_len: assert property (lo_cnt_r <= 9'(TEST_CYC))
		else $error("test pulse too long");
endmodule // fsw_chk

bind fsw_top fsw_chk #(.MS_CYCLES(MS_CYCLES)) chk_u (.SYS_CLK(SYS_CLK),
	.RST_N(RST_N), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .DI_PIN(DI_PIN), .DQ_PIN(DQ_PIN),
	.SENSOR_SUPPLY(SENSOR_SUPPLY), .SAFE_STATE(SAFE_STATE));

`default_nettype wire

// >>> fsw_ctl_model.sv
// Safety controller model: APB master that sends cyclic frames
`timescale 1ns/1ps
`default_nettype none

module fsw_ctl_model import fsw_pkg::*; (
	input wire logic clk,
	output logic [7:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	int seq = 0;

	// ------------------------------------------------------------
	// Bus cycle: setup, then access until ready
	// ------------------------------------------------------------
	initial begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // Released data is not left looking valid
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(a, 1'b1, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q,
		output logic e);
		xfer(a, 1'b0, 32'h0, q, e);
	endtask

	// One frame per call, next sequence number, destination dst
	task automatic send(input logic [3:0] v, input logic [7:0] dst);
		wr(OFS_FRAME, {16'(seq + 1), dst, 3'h0, 1'b1, v});
		if (dst == DEST_RST) begin
			seq++;
		end
	endtask
endmodule // fsw_ctl_model

`default_nettype wire

// >>> fsw_top_tb.sv
// Self-checking testbench for the fail-safe I/O image block
`timescale 1ns/1ps
`default_nettype none

module fsw_top_tb import fsw_pkg::*;;
	logic SYS_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [7:0] PADDR;
	logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SENSOR_SUPPLY, SAFE_STATE;
	logic [31:0] PWDATA, PRDATA;
	logic [15:0] DI_PIN = 16'h0000;
	logic [3:0] DQ_PIN;
	int bad_count = 0;
	int n_compared = 0;

	fsw_top #(.MS_CYCLES(20)) dut_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
		.PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.DI_PIN(DI_PIN), .DQ_PIN(DQ_PIN), .SENSOR_SUPPLY(SENSOR_SUPPLY),
		.SAFE_STATE(SAFE_STATE));
	fsw_ctl_model ctl_u (.clk(SYS_CLK), .paddr(PADDR), .psel(PSEL),
		.penable(PENABLE), .pwrite(PWRITE), .pwdata(PWDATA), .prdata(PRDATA),
		.pready(PREADY), .pslverr(PSLVERR));

	// ------------------------------------------------------------
	// Clock, checks and closing
	// ------------------------------------------------------------
	initial begin
		forever #5 SYS_CLK = ~SYS_CLK;
	end
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] ex, input string nm);
		logic [31:0] q;
		logic e;
		ctl_u.rd(a, q, e);
		chk(nm, ex, q & m);
		chk("pslverr", (a > 8'h3C) ? 32'h1 : 32'h0, {31'h0, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask
	task automatic test_done;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		test_done();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		cyc(10);
		RST_N <= 1'b1;
		ctl_u.wr(OFS_CTRL, 32'h0);
		cyc(250);
		ctl_u.send(4'hF, DEST_RST);
		@(posedge SYS_CLK) DI_PIN <= 16'hA5C3;
		cyc(10);
		rc(OFS_STATUS, 32'h3, 32'h3, "state run");
		rc(OFS_DI_IMG0, 32'hFFFFFFFF, 32'hFFFFA5C3, "single img");
		chk("dq pins", 32'hF, {28'h0, DQ_PIN});
		rc(OFS_DQ_OIMG0, 32'hF, 32'hF, "dq out img");
		rc(OFS_DQ_IMG0, 32'hF, 32'hF, "dq valid");
		ctl_u.wr(OFS_DI_PASS, 32'h1);
		cyc(3);
		rc(OFS_DI_IMG0, 32'hFFFFFFFF, 32'hFFFEA5C2, "pass img");
		// Channels 0 and 1 active, channel 1 passivated
		ctl_u.wr(OFS_DQ_CFG, 32'h23);
		cyc(3);
		chk("dq unused", 32'h1, {28'h0, DQ_PIN});
		rc(OFS_DQ_IMG0, 32'hF, 32'h1, "dq pass valid");
		ctl_u.wr(OFS_DI_PASS, 32'h0);
		ctl_u.wr(OFS_CTRL, 32'h1);
		@(posedge SYS_CLK) DI_PIN <= 16'h0F3F;
		cyc(10);
		rc(OFS_DI_IMG0, 32'hFFFFFFFF, 32'h00CF000F, "pair img");
		rc(OFS_DI_IMG2, 32'hFFFFFFFF, 32'h0, "ninth byte");
		rc(OFS_DQ_IMG1, 32'hFFFFFFFF, 32'h0, "sixth byte");
		rc(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
		// Default monitoring time of 3 ticks, counted from a fresh frame
		ctl_u.wr(OFS_CTRL, 32'h0);
		ctl_u.send(4'h1, DEST_RST);
		ctl_u.wr(OFS_MON_DEF, 32'h3);
		cyc(30);
		chk("safe early", 32'h0, {31'h0, SAFE_STATE});
		cyc(60);
		chk("safe late", 32'h1, {31'h0, SAFE_STATE});
		chk("safe dq", 32'h0, {28'h0, DQ_PIN});
		rc(OFS_STATUS, 32'h3, 32'h0, "state safe");
		rc(OFS_DI_IMG0, 32'hFFFF0000, 32'h0, "safe valid");
		ctl_u.wr(OFS_CTRL, 32'h8);
		ctl_u.send(4'h1, 8'h02);
		rc(OFS_STATUS, 32'h3, 32'h1, "wrong dest");
		ctl_u.send(4'h1, DEST_RST);
		rc(OFS_STATUS, 32'h3, 32'h3, "reintegrated");
		// Own monitoring time of 8 ticks overrides default
		ctl_u.wr(OFS_MON_OWN, 32'h8);
		ctl_u.wr(OFS_CTRL, 32'h4);
		ctl_u.send(4'h1, DEST_RST);
		cyc(100);
		chk("own early", 32'h0, {31'h0, SAFE_STATE});
		chk("supply idle", 32'h1, {31'h0, SENSOR_SUPPLY});
		cyc(100);
		chk("own late", 32'h1, {31'h0, SAFE_STATE});
		// Short-circuit test pulse reappears when enabled
		ctl_u.wr(OFS_CTRL, 32'h2);
		for (int i = 0; i < 40 && SENSOR_SUPPLY === 1'b1; i++) begin
			cyc(1);
		end
		chk("test pulse", 32'h0, {31'h0, SENSOR_SUPPLY});
		// Inputs still high at the end of the pulse latch as shorts
		cyc(210);
		rc(OFS_STATUS, 32'hFFFF0000, 32'h0F3F0000, "short faults");
		test_done();
	end
endmodule // fsw_top_tb

`default_nettype wire
